// *** verilog/pdb_cfg.svh ***
`ifndef PDB_CFG_SVH
`define PDB_CFG_SVH

// Register byte offsets on the configuration path.
`define PDB_OFS_BOOST_UP 8'hf6
`define PDB_OFS_BOOST_HI 8'hf7
`define PDB_OFS_BOOST_LO 8'hf8
`define PDB_OFS_SWAP 8'hfa

// Reset values.
`define PDB_RST_BYTE 8'h00
`define PDB_RST_UP 2'h0
`define PDB_RST_HI 6'h00

// Writable bit masks; reserved bits are outside them.
`define PDB_MASK_UP 8'h03
`define PDB_MASK_HI 8'h3f

// Port count, upstream at index 0.
`define PDB_NPORTS 8
`define PDB_UP_PORT 0

`endif

// *** verilog/pdb_pkg.sv ***
package pdb_pkg;

	typedef enum logic [1:0] {
		PDB_LVL_NORMAL = 2'b00,
		PDB_LVL_LOW = 2'b01,
		PDB_LVL_MEDIUM = 2'b10,
		PDB_LVL_HIGH = 2'b11
	} pdb_level_t;

	// One differential pair: p is the positive pin or D+ side, n the negative or D- side.
	typedef struct packed {
		logic p;
		logic n;
	} pdb_diff_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} pdb_cfg_req_t;

	// Exchanges the two halves of a pair when swap is set.
	function automatic pdb_diff_t pdb_swap(input pdb_diff_t d, input logic swap);
		pdb_diff_t r;
		r.p = swap ? d.n : d.p;
		r.n = swap ? d.p : d.n;
		return r;
	endfunction

endpackage

// *** verilog/pdb_pair_route.sv ***
`timescale 1ns/10ps
module pdb_pair_route (
	input wire logic clock_i,
	input wire logic sys_rst_i,
	input wire logic swap_i,
	input wire pdb_pkg::pdb_diff_t fn_tx_i,
	input wire pdb_pkg::pdb_diff_t fn_oe_n_i,
	input wire pdb_pkg::pdb_diff_t pin_in_i,
	output pdb_pkg::pdb_diff_t pin_out_o,
	output pdb_pkg::pdb_diff_t pin_oe_n_o,
	output pdb_pkg::pdb_diff_t fn_rx_o
);
	pdb_pkg::pdb_diff_t sync1_reg;
	pdb_pkg::pdb_diff_t sync2_reg;

	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			pin_out_o <= '0;
			pin_oe_n_o <= '1;
		end else begin
			pin_out_o <= pdb_pkg::pdb_swap(fn_tx_i, swap_i);
			pin_oe_n_o <= pdb_pkg::pdb_swap(fn_oe_n_i, swap_i);
		end
	end

	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
			fn_rx_o <= '0;
		end else begin
			sync1_reg <= pin_in_i;
			sync2_reg <= sync1_reg;
			fn_rx_o <= pdb_pkg::pdb_swap(sync2_reg, swap_i);
		end
	end

	straight_tx_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		!swap_i |=> pin_out_o.p == $past(fn_tx_i.p) && pin_out_o.n == $past(fn_tx_i.n))
		else $error("Unswapped pair does not carry D+ on the positive pin.");
	crossed_tx_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		swap_i |=> pin_out_o.n == $past(fn_tx_i.p) && pin_oe_n_o.n == $past(fn_oe_n_i.p))
		else $error("Swapped pair does not carry D+ on the negative pin.");
	crossed_rx_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		swap_i && $past(swap_i) |=> fn_rx_o.p == $past(pin_in_i.n, 3))
		else $error("Swapped pair does not sense D+ on the negative pin.");

endmodule

// *** verilog/pdb_bank.sv ***
`timescale 1ns/10ps
`include "pdb_cfg.svh"
// Contract
// - Upper boost register: port 7 bits 5:4, 6 bits 3:2, 5 bits 1:0; 7:6 reserved.
// - Lower boost register: port 4 bits 7:6, 3 bits 5:4, 2 bits 3:2, 1 bits 1:0.
// - Boost code 00 normal, 01 low, 10 medium, 11 high drive.
// - Swap bit 0: D+ on positive pin, D- on negative pin.
// - Swap bit 1: D+ on negative pin, D- on positive pin.
// - Swap register bit n controls downstream port n, n from 1 to 7.
// - Swap register bit 0 exchanges the upstream port's data pins.
// - Upstream boost in bits 1:0 of its own register; 7:2 reserved.
module pdb_bank (
	input wire logic clock_i,
	input wire logic sys_rst_i,
	input wire pdb_pkg::pdb_cfg_req_t cfg_req_i,
	output logic [7:0] cfg_rdata_o,
	output pdb_pkg::pdb_level_t upstream_drive_level_o,
	output pdb_pkg::pdb_level_t ds1_drive_level_o,
	output pdb_pkg::pdb_level_t ds2_drive_level_o,
	output pdb_pkg::pdb_level_t ds3_drive_level_o,
	output pdb_pkg::pdb_level_t ds4_drive_level_o,
	output pdb_pkg::pdb_level_t ds5_drive_level_o,
	output pdb_pkg::pdb_level_t ds6_drive_level_o,
	output pdb_pkg::pdb_level_t ds7_drive_level_o,
	output logic [7:0] pair_exchange_bits_o,
	input wire pdb_pkg::pdb_diff_t [`PDB_NPORTS-1:0] fn_tx_i,
	input wire pdb_pkg::pdb_diff_t [`PDB_NPORTS-1:0] fn_oe_n_i,
	output pdb_pkg::pdb_diff_t [`PDB_NPORTS-1:0] fn_rx_o,
	input wire pdb_pkg::pdb_diff_t [`PDB_NPORTS-1:0] pin_in_i,
	output pdb_pkg::pdb_diff_t [`PDB_NPORTS-1:0] pin_out_o,
	output pdb_pkg::pdb_diff_t [`PDB_NPORTS-1:0] pin_oe_n_o
);
	logic [1:0] boost_up_reg;
	logic [5:0] boost_hi_reg;
	logic [7:0] boost_lo_reg;
	logic [7:0] swap_reg;

	function automatic logic hit(input pdb_pkg::pdb_cfg_req_t q, input logic [7:0] ofs);
		return q.wr && (q.addr == ofs);
	endfunction

	// Boost registers keep only their defined fields.
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			boost_up_reg <= `PDB_RST_UP;
			boost_hi_reg <= `PDB_RST_HI;
			boost_lo_reg <= `PDB_RST_BYTE;
		end else begin
			if (hit(cfg_req_i, `PDB_OFS_BOOST_UP)) begin
				boost_up_reg <= cfg_req_i.wdata[1:0];
			end
			if (hit(cfg_req_i, `PDB_OFS_BOOST_HI)) begin
				boost_hi_reg <= cfg_req_i.wdata[5:0];
			end
			if (hit(cfg_req_i, `PDB_OFS_BOOST_LO)) begin
				boost_lo_reg <= cfg_req_i.wdata;
			end
		end
	end

	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			swap_reg <= `PDB_RST_BYTE;
		end else if (hit(cfg_req_i, `PDB_OFS_SWAP)) begin
			swap_reg <= cfg_req_i.wdata;
		end
	end

	// Read data is returned one cycle after the read strobe; unmapped offsets read zero.
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cfg_rdata_o <= `PDB_RST_BYTE;
		end else if (cfg_req_i.rd) begin
			unique case (cfg_req_i.addr)
				`PDB_OFS_BOOST_UP: cfg_rdata_o <= {6'h00, boost_up_reg};
				`PDB_OFS_BOOST_HI: cfg_rdata_o <= {2'h0, boost_hi_reg};
				`PDB_OFS_BOOST_LO: cfg_rdata_o <= boost_lo_reg;
				`PDB_OFS_SWAP: cfg_rdata_o <= swap_reg;
				default: cfg_rdata_o <= `PDB_RST_BYTE;
			endcase
		end
	end

	// Drive levels come straight from the field flops.
	assign upstream_drive_level_o = pdb_pkg::pdb_level_t'(boost_up_reg);
	assign ds7_drive_level_o = pdb_pkg::pdb_level_t'(boost_hi_reg[5:4]);
	assign ds6_drive_level_o = pdb_pkg::pdb_level_t'(boost_hi_reg[3:2]);
	assign ds5_drive_level_o = pdb_pkg::pdb_level_t'(boost_hi_reg[1:0]);
	assign ds4_drive_level_o = pdb_pkg::pdb_level_t'(boost_lo_reg[7:6]);
	assign ds3_drive_level_o = pdb_pkg::pdb_level_t'(boost_lo_reg[5:4]);
	assign ds2_drive_level_o = pdb_pkg::pdb_level_t'(boost_lo_reg[3:2]);
	assign ds1_drive_level_o = pdb_pkg::pdb_level_t'(boost_lo_reg[1:0]);
	assign pair_exchange_bits_o = swap_reg;

	// Each swap bit steers the pair of the port with the same index; index 0 is upstream.
	for (genvar i = 0; i < `PDB_NPORTS; i++) begin : g_port
		pdb_pair_route u_route (
			.clock_i(clock_i),
			.sys_rst_i(sys_rst_i),
			.swap_i(swap_reg[i]),
			.fn_tx_i(fn_tx_i[i]),
			.fn_oe_n_i(fn_oe_n_i[i]),
			.pin_in_i(pin_in_i[i]),
			.pin_out_o(pin_out_o[i]),
			.pin_oe_n_o(pin_oe_n_o[i]),
			.fn_rx_o(fn_rx_o[i])
		);
	end

	hi_fields_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		hit(cfg_req_i, `PDB_OFS_BOOST_HI) |=> ds7_drive_level_o == $past(cfg_req_i.wdata[5:4])
		&& ds5_drive_level_o == $past(cfg_req_i.wdata[1:0]))
		else $error("Upper boost fields not placed at 5:4 and 1:0.");
	lo_fields_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		hit(cfg_req_i, `PDB_OFS_BOOST_LO) |=> ds4_drive_level_o == $past(cfg_req_i.wdata[7:6])
		&& ds2_drive_level_o == $past(cfg_req_i.wdata[3:2]))
		else $error("Lower boost fields not placed at 7:6 and 3:2.");
	level_code_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		hit(cfg_req_i, `PDB_OFS_BOOST_LO) && cfg_req_i.wdata[1:0] == 2'h3
		|=> ds1_drive_level_o == pdb_pkg::PDB_LVL_HIGH)
		else $error("Code 11 does not select high drive.");
	up_field_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		hit(cfg_req_i, `PDB_OFS_BOOST_UP) |=> upstream_drive_level_o == $past(cfg_req_i.wdata[1:0]))
		else $error("Upstream boost not held in bits 1:0.");
	reserved_zero_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		cfg_req_i.rd && cfg_req_i.addr == `PDB_OFS_BOOST_HI |=> cfg_rdata_o[7:6] == 2'h0)
		else $error("Reserved upper boost bits do not read zero.");
	reserved_up_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		cfg_req_i.rd && cfg_req_i.addr == `PDB_OFS_BOOST_UP |=> cfg_rdata_o[7:2] == 6'h00)
		else $error("Reserved upstream boost bits do not read zero.");
	swap_bits_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		hit(cfg_req_i, `PDB_OFS_SWAP) |=> pair_exchange_bits_o == $past(cfg_req_i.wdata))
		else $error("Swap register does not take the written byte.");
	up_swap_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		swap_reg[`PDB_UP_PORT] |=> pin_out_o[`PDB_UP_PORT].p == $past(fn_tx_i[`PDB_UP_PORT].n))
		else $error("Upstream pins not exchanged while bit 0 is set.");

	// Remaining field positions of both downstream boost registers.
	ds6_field_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		hit(cfg_req_i, `PDB_OFS_BOOST_HI) |=> ds6_drive_level_o == $past(cfg_req_i.wdata[3:2]))
		else $error("Port 6 boost not held in bits 3:2.");
	ds3_field_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		hit(cfg_req_i, `PDB_OFS_BOOST_LO) |=> ds3_drive_level_o == $past(cfg_req_i.wdata[5:4]))
		else $error("Port 3 boost not held in bits 5:4.");
	ds1_field_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		hit(cfg_req_i, `PDB_OFS_BOOST_LO) |=> ds1_drive_level_o == $past(cfg_req_i.wdata[1:0]))
		else $error("Port 1 boost not held in bits 1:0.");

	// Every code maps to its own drive level.
	level_normal_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		hit(cfg_req_i, `PDB_OFS_BOOST_LO) && cfg_req_i.wdata[1:0] == 2'h0
		|=> ds1_drive_level_o == pdb_pkg::PDB_LVL_NORMAL)
		else $error("Code 00 does not select normal drive.");
	level_low_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		hit(cfg_req_i, `PDB_OFS_BOOST_LO) && cfg_req_i.wdata[1:0] == 2'h1
		|=> ds1_drive_level_o == pdb_pkg::PDB_LVL_LOW)
		else $error("Code 01 does not select low drive.");
	level_medium_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		hit(cfg_req_i, `PDB_OFS_BOOST_LO) && cfg_req_i.wdata[1:0] == 2'h2
		|=> ds1_drive_level_o == pdb_pkg::PDB_LVL_MEDIUM)
		else $error("Code 10 does not select medium drive.");

	// Registers change only on a write to their own offset.
	hi_hold_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		!hit(cfg_req_i, `PDB_OFS_BOOST_HI) |=> $stable(boost_hi_reg))
		else $error("Upper boost register changed without a write.");
	lo_hold_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		!hit(cfg_req_i, `PDB_OFS_BOOST_LO) |=> $stable(boost_lo_reg))
		else $error("Lower boost register changed without a write.");
	up_hold_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		!hit(cfg_req_i, `PDB_OFS_BOOST_UP) |=> $stable(boost_up_reg))
		else $error("Upstream boost register changed without a write.");
	swap_hold_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		!hit(cfg_req_i, `PDB_OFS_SWAP) |=> $stable(swap_reg))
		else $error("Swap register changed without a write.");

	// Reserved bits are dropped on a write.
	hi_mask_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		hit(cfg_req_i, `PDB_OFS_BOOST_HI)
		|=> {2'h0, boost_hi_reg} == ($past(cfg_req_i.wdata) & `PDB_MASK_HI))
		else $error("Reserved upper boost bits were stored.");
	up_mask_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		hit(cfg_req_i, `PDB_OFS_BOOST_UP)
		|=> {6'h00, boost_up_reg} == ($past(cfg_req_i.wdata) & `PDB_MASK_UP))
		else $error("Reserved upstream boost bits were stored.");

	// Read data carries the register value of the strobe cycle.
	hi_rdata_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		cfg_req_i.rd && cfg_req_i.addr == `PDB_OFS_BOOST_HI
		|=> cfg_rdata_o[5:0] == $past(boost_hi_reg))
		else $error("Upper boost read does not return the register.");
	lo_rdata_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		cfg_req_i.rd && cfg_req_i.addr == `PDB_OFS_BOOST_LO
		|=> cfg_rdata_o == $past(boost_lo_reg))
		else $error("Lower boost read does not return the register.");
	up_rdata_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		cfg_req_i.rd && cfg_req_i.addr == `PDB_OFS_BOOST_UP
		|=> cfg_rdata_o[1:0] == $past(boost_up_reg))
		else $error("Upstream boost read does not return the register.");
	swap_rdata_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		cfg_req_i.rd && cfg_req_i.addr == `PDB_OFS_SWAP
		|=> cfg_rdata_o == $past(swap_reg))
		else $error("Swap read does not return the register.");

	// Swap bits steer the pair of the matching port.
	ds7_swap_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		swap_reg[7] |=> pin_out_o[7].p == $past(fn_tx_i[7].n))
		else $error("Port 7 pins not exchanged while bit 7 is set.");
	ds1_swap_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		swap_reg[1] |=> pin_out_o[1].n == $past(fn_tx_i[1].p))
		else $error("Port 1 pins not exchanged while bit 1 is set.");
	up_straight_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		!swap_reg[`PDB_UP_PORT] |=> pin_out_o[`PDB_UP_PORT].p == $past(fn_tx_i[`PDB_UP_PORT].p))
		else $error("Upstream pins exchanged while bit 0 is clear.");
	ds3_oe_swap_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		swap_reg[3] |=> pin_oe_n_o[3].p == $past(fn_oe_n_i[3].n))
		else $error("Port 3 enables not exchanged while bit 3 is set.");
	ds4_straight_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		!swap_reg[4] |=> pin_oe_n_o[4].n == $past(fn_oe_n_i[4].n))
		else $error("Port 4 enables exchanged while bit 4 is clear.");

endmodule

// *** tb/tb.sv ***
`timescale 1ns/10ps
module tb;
	logic clock_i = 1'b0;
	logic sys_rst_i = 1'b1;
	pdb_pkg::pdb_cfg_req_t cfg_req_i = '0;
	logic [7:0] cfg_rdata_o;
	logic [7:0] pair_exchange_bits_o;
	pdb_pkg::pdb_level_t up_l, l1, l2, l3, l4, l5, l6, l7;
	pdb_pkg::pdb_diff_t [7:0] fn_tx_i = '0;
	pdb_pkg::pdb_diff_t [7:0] fn_oe_n_i = '1;
	pdb_pkg::pdb_diff_t [7:0] pin_in_i = '0;
	pdb_pkg::pdb_diff_t [7:0] fn_rx_o, pin_out_o, pin_oe_n_o;
	int mismatches = 0;
	int total_checks = 0;
	logic [7:0] up_m = 8'h00, hi_m = 8'h00, lo_m = 8'h00, sw_m = 8'h00;
	logic [7:0] adr[8] = '{8'hf6, 8'hf7, 8'hf8, 8'hfa, 8'hf9, 8'hf5, 8'hfb, 8'h00};
	logic [7:0] a, v;

	pdb_bank dut_u (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .cfg_req_i(cfg_req_i),
		.cfg_rdata_o(cfg_rdata_o), .upstream_drive_level_o(up_l),
		.ds1_drive_level_o(l1), .ds2_drive_level_o(l2), .ds3_drive_level_o(l3),
		.ds4_drive_level_o(l4), .ds5_drive_level_o(l5), .ds6_drive_level_o(l6),
		.ds7_drive_level_o(l7), .pair_exchange_bits_o(pair_exchange_bits_o),
		.fn_tx_i(fn_tx_i), .fn_oe_n_i(fn_oe_n_i), .fn_rx_o(fn_rx_o),
		.pin_in_i(pin_in_i), .pin_out_o(pin_out_o), .pin_oe_n_o(pin_oe_n_o));

	initial begin
		forever #2 clock_i = ~clock_i;
	end

	// Expected register contents, reserved bits cleared.
	function automatic logic [7:0] exp_rd(input logic [7:0] ad);
		case (ad)
			8'hf6: return up_m;
			8'hf7: return hi_m;
			8'hf8: return lo_m;
			8'hfa: return sw_m;
			default: return 8'h00;
		endcase
	endfunction

	// Exchanges the two halves of every pair whose swap bit is set.
	function automatic logic [15:0] route(input logic [15:0] d, input logic [7:0] s);
		logic [15:0] r;
		r = d;
		for (int i = 0; i < 8; i++) if (s[i]) r[2*i+1 -: 2] = {d[2*i], d[2*i+1]};
		return r;
	endfunction

	task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_vec(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] ad, input logic [7:0] d);
		@(posedge clock_i);
		cfg_req_i <= {1'b1, 1'b0, ad, d};
		@(posedge clock_i);
		cfg_req_i <= '0;
		case (ad)
			8'hf6: up_m = d & 8'h03;
			8'hf7: hi_m = d & 8'h3f;
			8'hf8: lo_m = d;
			8'hfa: sw_m = d;
			default: ;
		endcase
	endtask

	task automatic rd(input logic [7:0] ad, output logic [7:0] d);
		@(posedge clock_i);
		cfg_req_i <= {1'b0, 1'b1, ad, 8'h00};
		@(posedge clock_i);
		cfg_req_i <= '0;
		#1 d = cfg_rdata_o;
	endtask

	task automatic chk_lvl();
		chk_vec({up_l, l7, l6, l5, l4, l3, l2, l1}, {up_m[1:0], hi_m[5:0], lo_m});
		chk_reg(pair_exchange_bits_o, sw_m);
	endtask

	task automatic finish_test();
		$display("checks=%0d mismatches=%0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	initial begin
		#20000;
		mismatches++;
		finish_test();
	end

	initial begin
		void'($urandom(50094));
		repeat (16) @(posedge clock_i);
		sys_rst_i <= 1'b0;
		#1 chk_lvl();
		chk_vec(pin_oe_n_o, 16'hffff);
		wr(8'hf6, 8'h00);
		wr(8'hf7, 8'hff);
		wr(8'hf6, 8'hff);
		wr(8'hf8, 8'ha5);
		wr(8'hf9, 8'hff);
		#1 chk_lvl();
		for (int i = 0; i < 60; i++) begin
			if (i >= 4) wr(adr[$urandom % 8], 8'($urandom));
			#1 chk_lvl();
			a = adr[i < 8 ? i : $urandom % 8];
			rd(a, v);
			chk_reg(v, exp_rd(a));
		end
		for (int i = 0; i < 40; i++) begin
			if (i % 5 == 0) wr(8'hfa, i == 0 ? 8'h01 : 8'($urandom));
			@(posedge clock_i);
			fn_tx_i <= 16'($urandom);
			fn_oe_n_i <= 16'($urandom);
			pin_in_i <= 16'($urandom);
			@(posedge clock_i);
			#1 chk_vec(pin_out_o, route(fn_tx_i, sw_m));
			chk_vec(pin_oe_n_o, route(fn_oe_n_i, sw_m));
			repeat (2) @(posedge clock_i);
			#1 chk_vec(fn_rx_o, route(pin_in_i, sw_m));
		end
		@(posedge clock_i);
		sys_rst_i <= 1'b1;
		@(posedge clock_i);
		sys_rst_i <= 1'b0;
		{up_m, hi_m, lo_m, sw_m} = '0;
		#1 chk_lvl();
		chk_vec(pin_oe_n_o, 16'hffff);
		chk_vec(pin_out_o, 16'h0000);
		chk_vec(fn_rx_o, 16'h0000);
		chk_reg(cfg_rdata_o, 8'h00);
		finish_test();
	end
endmodule
